// ===== src/lvrc_top.sv
// Limit value relay control: compares results with two thresholds, drives
// two limit relays, the indicator, purge valves and volume triggering.
// Assumes APB from software and result strobes from the analysis logic.
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Above a threshold: indicator red and relay acts; otherwise green.
// - Limit mode: each relay follows its own threshold independently.
// - Two-point: upper relay on above second, off below first.
// - Two-point: lower relay still acts as plain first-threshold relay.
// - Range: relay one below first threshold, relay two above second.
// - Per relay duration, impulse or interval; time up to 99m99s.
// - Exceed count one to three, default one, one means immediate.
// - Count two: retry analysis at once, switch if it exceeds too.
// - Count three: three consecutive exceedances; re-arm after below.
// - Duration: relay held while exceeded, released when not.
// - Impulse: on for set time once; new pulse only after below.
// - Purge opens inlet and outlet together for purge seconds, default 0.
// - Analyses never start closer than the purge duration.
// - After an exceedance, purge is extended by extra flush time.
// - Meter pulses scaled by 1..1000 litres, default 100.
// - Volume mode: analysis starts when metered volume reaches target.
module lvrc_top
  import lvrc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        result_valid,
  input  wire logic [15:0] result_value,
  input  wire logic        meter_pulse_input,
  input  wire logic        analysis_busy,
  output logic             analysis_start,
  output logic             lower_limit_relay,
  output logic             upper_limit_relay,
  output logic             indicator_red,
  output logic             indicator_green,
  output logic             inlet_valve,
  output logic             outlet_valve,
  output logic             irq
);

  // ===========================================================
  // Register bus
  logic [1:0]  mode_q;
  logic [2:0]  scale_q;
  logic        voltrig_q;
  logic [15:0] first_threshold_q, second_threshold_q;
  lvrc_relay_cfg_t rly1_q, rly2_q;
  logic [12:0] purge_q, extra_q;
  logic [23:0] target_q;
  logic [15:0] last_result_q;
  logic [2:0]  irq_stat_q, irq_mask_q;
  logic        sw_start_q;

  wire acc = psel && penable;
  wire wr  = acc && pwrite;
  wire rd  = acc && !pwrite;
  wire [7:0] a = paddr[7:0];
  wire hit = (paddr[31:8] == 24'h0) && (a[1:0] == 2'h0) && (a <= OFS_IRQ_MASK);

  assign pready  = 1'b1;
  assign pslverr = acc && !hit;

  lvrc_relay_cfg_t w_rly;
  assign w_rly.func   = lvrc_func_t'(pwdata[RLY_FUNC_LSB +: 2]);
  assign w_rly.count  = pwdata[RLY_COUNT_LSB +: 2];
  assign w_rly.time_s = (pwdata[RLY_TIME_LSB +: 13] > MAX_TIME_S)
                        ? MAX_TIME_S : pwdata[RLY_TIME_LSB +: 13];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_q             <= RST_MODE;
      scale_q            <= RST_SCALE;
      voltrig_q          <= 1'b0;
      first_threshold_q  <= 16'h0000;
      second_threshold_q <= 16'h0000;
      rly1_q             <= '{LVRC_FN_DURATION, RST_COUNT, 13'h0000};
      rly2_q             <= '{LVRC_FN_DURATION, RST_COUNT, 13'h0000};
      purge_q            <= RST_PURGE;
      extra_q            <= RST_EXTRA;
      target_q           <= 24'h000000;
      irq_mask_q         <= 3'h0;
    end else if (wr && hit) begin
      case (a)
        OFS_CTRL: begin
          mode_q    <= pwdata[CTRL_MODE_LSB +: 2];
          scale_q   <= pwdata[CTRL_SCALE_LSB +: 3];
          voltrig_q <= pwdata[CTRL_VOLTRIG];
        end
        OFS_LIMITS: begin
          first_threshold_q  <= pwdata[15:0];
          second_threshold_q <= pwdata[31:16];
        end
        OFS_RELAY1:   rly1_q     <= w_rly;
        OFS_RELAY2:   rly2_q     <= w_rly;
        OFS_PURGE: begin
          purge_q <= pwdata[PURGE_BASE_LSB +: 13];
          extra_q <= pwdata[PURGE_EXTRA_LSB +: 13];
        end
        OFS_VOLUME:   target_q   <= pwdata[23:0];
        OFS_IRQ_MASK: irq_mask_q <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // ===========================================================
  // Time base and meter pin
  logic [27:0] div_q;
  wire sec_tick = (div_q == 28'(SEC_CYCLES - 1));
  logic [1:0] wm_sync_q;
  logic       wm_last_q;
  wire wm_rise = wm_sync_q[1] && !wm_last_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_q     <= 28'h0000000;
      wm_sync_q <= 2'h0;
      wm_last_q <= 1'b0;
    end else begin
      div_q     <= sec_tick ? 28'h0000000 : div_q + 28'h0000001;
      wm_sync_q <= {wm_sync_q[0], meter_pulse_input};
      wm_last_q <= wm_sync_q[1];
    end
  end

  // ===========================================================
  // Comparison per channel
  wire above1 = result_value > first_threshold_q;
  wire above2 = result_value > second_threshold_q;
  wire low1   = result_value < first_threshold_q;
  lvrc_cmp_t cmp1, cmp2;
  wire rng = (mode_q == LVRC_MODE_RANGE);
  assign cmp1.valid  = result_valid;
  assign cmp1.exceed = rng ? low1 : above1;
  assign cmp1.below  = rng ? !low1 : !above1;
  assign cmp2.valid  = result_valid;
  assign cmp2.exceed = above2;
  assign cmp2.below  = !above2;

  logic on1, on2, retry1, retry2, trip1, trip2;
  lvrc_relay_ch u_ch1 (
    .clock     (clock),
    .reset_n   (reset_n),
    .cfg       (rly1_q),
    .cmp       (cmp1),
    .sec_tick  (sec_tick),
    .relay_on  (on1),
    .retry_req (retry1),
    .tripped   (trip1)
  );
  lvrc_relay_ch u_ch2 (
    .clock     (clock),
    .reset_n   (reset_n),
    .cfg       (rly2_q),
    .cmp       (cmp2),
    .sec_tick  (sec_tick),
    .relay_on  (on2),
    .retry_req (retry2),
    .tripped   (trip2)
  );

  // ===========================================================
  // Two-point hysteresis and outputs
  logic twopt_q, red_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      twopt_q       <= 1'b0;
      red_q         <= 1'b0;
      last_result_q <= 16'h0000;
    end else if (result_valid) begin
      last_result_q <= result_value;
      if (above2) twopt_q <= 1'b1;
      else if (low1) twopt_q <= 1'b0;
      red_q <= cmp1.exceed || cmp2.exceed;
    end
  end

  assign lower_limit_relay = on1;
  assign upper_limit_relay = (mode_q == LVRC_MODE_TWOPT) ? twopt_q : on2;
  assign indicator_red     = red_q;
  assign indicator_green   = !red_q;

  // ===========================================================
  // Purge and analysis sequencing
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_PURGE = 3'b010,
    ST_ANAL  = 3'b100
  } lvrc_state_t;
  lvrc_state_t st_q, st_d;
  logic [13:0] ptmr_q, ptmr_d;
  logic        flush_due_q, retry_q;
  logic [27:0] vol_q;
  wire vol_hit = voltrig_q && (target_q != 24'h0)
                 && (vol_q >= 28'(target_q) * 28'(PULSE_FRAC_W));
  lvrc_dl_t dl;
  always_comb begin
    case (scale_q)
      3'h0: dl = 14'h000A;
      3'h1: dl = 14'h0019;
      3'h2: dl = 14'h0032;
      3'h3: dl = 14'h0064;
      3'h4: dl = 14'h03E8;
      3'h5: dl = 14'h1388;
      3'h6: dl = 14'h2710;
      default: dl = 14'h03E8;
    endcase
  end
  wire trig = sw_start_q || retry_q || vol_hit;

  always_comb begin
    st_d   = st_q;
    ptmr_d = ptmr_q;
    case (st_q)
      ST_IDLE: if (trig) begin
        st_d   = ST_PURGE;
        ptmr_d = {1'b0, purge_q} + (flush_due_q ? {1'b0, extra_q} : 14'h0);
      end
      ST_PURGE: begin
        if (ptmr_q == 14'h0 && analysis_busy) st_d = ST_ANAL;
        else if (ptmr_q != 14'h0 && sec_tick) ptmr_d = ptmr_q - 14'h0001;
      end
      ST_ANAL: if (result_valid) st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q        <= ST_IDLE;
      ptmr_q      <= 14'h0000;
      flush_due_q <= 1'b0;
      retry_q     <= 1'b0;
      sw_start_q  <= 1'b0;
      vol_q       <= 28'h0000000;
    end else begin
      st_q   <= st_d;
      ptmr_q <= ptmr_d;
      if (trip1 || trip2) flush_due_q <= 1'b1;
      else if (st_q == ST_IDLE && trig) flush_due_q <= 1'b0;
      if (retry1 || retry2) retry_q <= 1'b1;
      else if (st_q == ST_IDLE) retry_q <= 1'b0;
      if (wr && a == OFS_CTRL && pwdata[CTRL_ANALYSE]) sw_start_q <= 1'b1;
      else if (st_q == ST_IDLE) sw_start_q <= 1'b0;
      if (st_q == ST_IDLE && vol_hit) vol_q <= 28'h0000000;
      else if (wm_rise) vol_q <= vol_q + 28'(dl);
    end
  end

  assign inlet_valve    = (st_q == ST_PURGE) && (ptmr_q != 14'h0);
  assign outlet_valve   = (st_q == ST_PURGE) && (ptmr_q != 14'h0);
  assign analysis_start = (st_q == ST_PURGE) && (ptmr_q == 14'h0);

  // ===========================================================
  // Interrupts: result, relay one trip, relay two trip
  wire [2:0] ev = {trip2, trip1, result_valid};
  wire stat_rd = rd && a == OFS_IRQ_STAT;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) irq_stat_q <= 3'h0;
    else irq_stat_q <= (stat_rd ? 3'h0 : irq_stat_q) | ev;
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  always_comb begin
    prdata = 32'h00000000;
    case (a)
      OFS_CTRL:     prdata = {22'h0, 1'b0, voltrig_q, 1'b0, scale_q,
                              2'h0, mode_q};
      OFS_LIMITS:   prdata = {second_threshold_q, first_threshold_q};
      OFS_RELAY1:   prdata = {3'h0, rly1_q.time_s, 10'h0, rly1_q.count,
                              2'h0, rly1_q.func};
      OFS_RELAY2:   prdata = {3'h0, rly2_q.time_s, 10'h0, rly2_q.count,
                              2'h0, rly2_q.func};
      OFS_PURGE:    prdata = {3'h0, extra_q, 3'h0, purge_q};
      OFS_VOLUME:   prdata = {8'h0, target_q};
      OFS_RESULT:   prdata = {16'h0, last_result_q};
      OFS_STATUS:   prdata = {24'h0, st_q, red_q, upper_limit_relay, on1,
                              flush_due_q, retry_q};
      OFS_IRQ_STAT: prdata = {29'h0, irq_stat_q};
      OFS_IRQ_MASK: prdata = {29'h0, irq_mask_q};
      default:      prdata = 32'h00000000;
    endcase
  end

endmodule // lvrc_top
`default_nettype wire

// ===== shared/lvrc_pkg.sv
// Package for the limit value relay control block: register map, fields,
// reset values and timing constants.
// Assumes a 200 MHz clock and a 32-bit APB register bus.
package lvrc_pkg;

  // ===========================================================
  // Timing
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned SEC_TIME_S    = 1;
  localparam int unsigned SEC_CYCLES    = CLK_HZ * SEC_TIME_S;
  localparam logic [4:0]  PULSE_FRAC_W  = 5'h0A;

  // ===========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_LIMITS    = 8'h04;
  localparam logic [7:0] OFS_RELAY1    = 8'h08;
  localparam logic [7:0] OFS_RELAY2    = 8'h0C;
  localparam logic [7:0] OFS_PURGE     = 8'h10;
  localparam logic [7:0] OFS_VOLUME    = 8'h14;
  localparam logic [7:0] OFS_RESULT    = 8'h18;
  localparam logic [7:0] OFS_STATUS    = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h24;

  // ===========================================================
  // Field positions
  localparam int CTRL_MODE_LSB   = 0;   // [1:0] limit/two-point/range
  localparam int CTRL_SCALE_LSB  = 4;   // [6:4] meter scale select
  localparam int CTRL_VOLTRIG    = 8;   // volume triggered analysis
  localparam int CTRL_ANALYSE    = 9;   // write 1: request analysis
  localparam int RLY_FUNC_LSB    = 0;   // [1:0] duration/impulse/interval
  localparam int RLY_COUNT_LSB   = 4;   // [5:4] exceed count 1..3
  localparam int RLY_TIME_LSB    = 16;  // [28:16] time in seconds
  localparam int PURGE_BASE_LSB  = 0;   // [12:0] purge seconds
  localparam int PURGE_EXTRA_LSB = 16;  // [28:16] extra flush seconds

  // ===========================================================
  // Reset values
  localparam logic [1:0]  RST_MODE   = 2'h0;
  localparam logic [2:0]  RST_SCALE  = 3'h4;   // 100 l per pulse
  localparam logic [1:0]  RST_COUNT  = 2'h1;
  localparam logic [12:0] RST_PURGE  = 13'h0000;
  localparam logic [12:0] RST_EXTRA  = 13'h0000;
  localparam logic [12:0] MAX_TIME_S = 13'h1797; // 99 min 99 s = 6039 s

  // ===========================================================
  // Types
  typedef enum logic [1:0] {
    LVRC_MODE_LIMIT = 2'h0,
    LVRC_MODE_TWOPT = 2'h1,
    LVRC_MODE_RANGE = 2'h2
  } lvrc_mode_t;

  typedef enum logic [1:0] {
    LVRC_FN_DURATION = 2'h0,
    LVRC_FN_IMPULSE  = 2'h1,
    LVRC_FN_INTERVAL = 2'h2
  } lvrc_func_t;

  typedef struct packed {
    lvrc_func_t  func;
    logic [1:0]  count;
    logic [12:0] time_s;
  } lvrc_relay_cfg_t;

  typedef struct packed {
    logic        valid;
    logic        exceed;
    logic        below;
  } lvrc_cmp_t;

  // Litres per pulse, in tenths of a litre
  typedef logic [13:0] lvrc_dl_t;

endpackage

// ===== src/lvrc_relay_ch.sv
// One limit relay channel: exceed counting and switching function.
// Assumes the result strobe and one-second tick come from the same clock.
`timescale 1ns/1ps
`default_nettype none
module lvrc_relay_ch
  import lvrc_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            reset_n,
  input  wire lvrc_relay_cfg_t cfg,
  input  wire lvrc_cmp_t       cmp,
  input  wire logic            sec_tick,
  output logic                 relay_on,
  output logic                 retry_req,
  output logic                 tripped
);

  logic [1:0]  hits_q, hits_d;
  logic        armed_q, armed_d;
  logic        act_q, act_d;
  logic        phase_q, phase_d;
  logic [12:0] tmr_q, tmr_d;
  logic [1:0]  need;
  logic        fire;

  assign need = (cfg.count == 2'h0) ? 2'h1 : cfg.count;
  assign fire = cmp.valid && cmp.exceed && armed_q
                && ((hits_q + 2'h1) >= need);

  always_comb begin
    hits_d  = hits_q;
    armed_d = armed_q;
    act_d   = act_q;
    phase_d = phase_q;
    tmr_d   = tmr_q;
    if (cmp.valid && cmp.below) begin
      hits_d  = 2'h0;
      armed_d = 1'b1;
    end else if (cmp.valid && cmp.exceed && armed_q) begin
      hits_d = (hits_q + 2'h1 >= need) ? 2'h0 : hits_q + 2'h1;
    end
    if (fire) begin
      armed_d = 1'b0;
      act_d   = 1'b1;
      phase_d = 1'b1;
      tmr_d   = cfg.time_s;
    end
    case (cfg.func)
      LVRC_FN_DURATION: begin
        if (cmp.valid && cmp.below) act_d = 1'b0;
      end
      LVRC_FN_IMPULSE: begin
        if (act_q && sec_tick && !fire) begin
          if (tmr_q <= 13'h0001) act_d = 1'b0;
          else tmr_d = tmr_q - 13'h0001;
        end
        if (act_q && tmr_q == 13'h0000 && !fire) act_d = 1'b0;
      end
      LVRC_FN_INTERVAL: begin
        if (cmp.valid && cmp.below) act_d = 1'b0;
        else if (act_q && sec_tick && !fire) begin
          if (tmr_q <= 13'h0001) begin
            phase_d = ~phase_q;
            tmr_d   = cfg.time_s;
          end else begin
            tmr_d = tmr_q - 13'h0001;
          end
        end
      end
      default: act_d = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hits_q  <= 2'h0;
      armed_q <= 1'b1;
      act_q   <= 1'b0;
      phase_q <= 1'b0;
      tmr_q   <= 13'h0000;
    end else begin
      hits_q  <= hits_d;
      armed_q <= armed_d;
      act_q   <= act_d;
      phase_q <= phase_d;
      tmr_q   <= tmr_d;
    end
  end

  // Retry asked when an exceedance did not yet reach the count
  assign retry_req = cmp.valid && cmp.exceed && armed_q && !fire;
  assign relay_on  = act_q && ((cfg.func != LVRC_FN_INTERVAL) || phase_q);
  assign tripped   = fire;

endmodule // lvrc_relay_ch
`default_nettype wire

// ===== tb/lvrc_checker.sv
// Concurrent checks on the ports of the limit value relay control top.
// Assumes it is bound into lvrc_top and shares its single clock domain.
`timescale 1ns/1ps
`default_nettype none
module lvrc_checker (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        result_valid,
  input wire logic [15:0] result_value,
  input wire logic        meter_pulse_input,
  input wire logic        analysis_busy,
  input wire logic        analysis_start,
  input wire logic        lower_limit_relay,
  input wire logic        upper_limit_relay,
  input wire logic        indicator_red,
  input wire logic        indicator_green,
  input wire logic        inlet_valve,
  input wire logic        outlet_valve,
  input wire logic        irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Properties
  a_ind_exclusive: assert property
    (indicator_red != indicator_green)
    else $error("indicator red and green not exclusive");
  a_ind_cause: assert property ($changed(indicator_red) |->
    $past(result_valid) || $past(psel && penable && pwrite))
    else $error("indicator changed without result or write");
  a_valves_paired: assert property (inlet_valve == outlet_valve)
    else $error("inlet and outlet valves differ");
  a_start_after_purge: assert property
    (analysis_start |-> !inlet_valve)
    else $error("analysis start while purging");
  a_reset_idle: assert property ($rose(reset_n) |-> indicator_green &&
    !lower_limit_relay && !upper_limit_relay && !inlet_valve && !irq)
    else $error("outputs not idle after reset");
  a_ready_zero_wait: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  a_unmapped_zero: assert property (psel && penable && !pwrite && pslverr
    |-> prdata == 32'h0)
    else $error("refused read returns nonzero data");
  a_mapped_no_err: assert property (psel && penable && paddr[31:8] == 24'h0
    && paddr[1:0] == 2'h0 && paddr[7:0] <= 8'h24 |-> !pslverr)
    else $error("mapped register access refused");
  a_irq_read_clear: assert property (psel && penable && !pwrite &&
    paddr == 32'h20 && !result_valid && !$past(result_valid) &&
    !$past(result_valid, 2) |=> !irq)
    else $error("interrupt stays after status read");
endmodule // lvrc_checker

bind lvrc_top lvrc_checker i_checker (
  .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .result_valid(result_valid),
  .result_value(result_value), .meter_pulse_input(meter_pulse_input),
  .analysis_busy(analysis_busy), .analysis_start(analysis_start),
  .lower_limit_relay(lower_limit_relay),
  .upper_limit_relay(upper_limit_relay), .indicator_red(indicator_red),
  .indicator_green(indicator_green), .inlet_valve(inlet_valve),
  .outlet_valve(outlet_valve), .irq(irq));
`default_nettype wire

// ===== tb/lvrc_field_model.sv
// Far-side model: water meter pulse source and analyser busy flag.
// Assumes the bench calls its tasks from the block's clock domain.
`timescale 1ns/1ps
`default_nettype none
module lvrc_field_model (
  input  wire logic clock,
  output logic      meter_pulse_input,
  output logic      analysis_busy
);
  initial begin
    meter_pulse_input = 1'b0;
    analysis_busy     = 1'b0;
  end
  // Pulses span eight clocks so the synchroniser sees each one
  task automatic send_pulses(input int n);
    repeat (n) begin
      @(posedge clock) meter_pulse_input <= 1'b1;
      repeat (8) @(posedge clock);
      meter_pulse_input <= 1'b0;
      repeat (8) @(posedge clock);
    end
  endtask
  task automatic run_analysis();
    @(posedge clock) analysis_busy <= 1'b1;
    repeat (4) @(posedge clock);
    analysis_busy <= 1'b0;
  endtask
endmodule // lvrc_field_model
`default_nettype wire

// ===== tb/test_limit_value_relay_control.sv
// Self-checking bench for the limit value relay control top.
// Assumes lvrc_pkg, lvrc_top, the checker and the field model are compiled.
`timescale 1ns/1ps
`default_nettype none
module test_limit_value_relay_control;
  import lvrc_pkg::*;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic        result_valid = 1'b0;
  logic [15:0] result_value = 16'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err_seen, meter_pulse_input, analysis_busy;
  logic        analysis_start, lower_limit_relay, upper_limit_relay;
  logic        indicator_red, indicator_green, inlet_valve, outlet_valve, irq;
  int          err_total = 0;
  int          checks_done = 0;
  int          cycles = 0;

  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      close_out();
    end
  end

  lvrc_top i_dut (.clock, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .result_valid, .result_value,
    .meter_pulse_input, .analysis_busy, .analysis_start, .lower_limit_relay,
    .upper_limit_relay, .indicator_red, .indicator_green, .inlet_valve,
    .outlet_valve, .irq);
  lvrc_field_model i_field (.clock, .meter_pulse_input, .analysis_busy);

  // ==========================================================
  // Helpers
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {24'h0, a};
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd       = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic res(input logic [15:0] v);
    @(posedge clock);
    result_value <= v;
    result_valid <= 1'b1;
    @(posedge clock);
    result_valid <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic rel(input logic [1:0] e);
    check("relays", {30'h0, lower_limit_relay, upper_limit_relay}, {30'h0, e});
  endtask
  task automatic wait_start();
    int n;
    n = 0;
    while (analysis_start !== 1'b1 && n < 200) begin
      @(posedge clock);
      #1;
      n++;
    end
    check("analysis_start", {31'h0, analysis_start}, 32'h1);
    i_field.run_analysis();
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    check("indicator", {30'h0, indicator_red, indicator_green}, 32'h1);
    apb(1'b0, OFS_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h40);
    apb(1'b0, OFS_RELAY1, 32'h0);
    check("relay1 reset", rd, 32'h10);
    apb(1'b0, OFS_RELAY2, 32'h0);
    check("relay2 reset", rd, 32'h10);
    apb(1'b0, OFS_PURGE, 32'h0);
    check("purge reset", rd, 32'h0);
    apb(1'b1, OFS_RELAY2, 32'h1FFF0010);
    apb(1'b0, OFS_RELAY2, 32'h0);
    check("time clamp", rd, {3'h0, MAX_TIME_S, 16'h0010});
    apb(1'b1, OFS_RELAY2, 32'h10);
    apb(1'b1, OFS_PURGE, 32'h3D);
    apb(1'b0, OFS_PURGE, 32'h0);
    check("purge time", rd, 32'h3D);
    apb(1'b1, OFS_PURGE, 32'h0);
    apb(1'b0, 8'h28, 32'h0);
    check("unmapped", {rd[31:1], err_seen}, 32'h1);
  endtask
  task automatic t_limit();
    apb(1'b1, OFS_LIMITS, 32'h00C80064);
    res(16'd150);
    rel(2'b10);
    check("red", {31'h0, indicator_red}, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    check("flush due", {31'h0, rd[1]}, 32'h1);
    res(16'd250);
    rel(2'b11);
    res(16'd100);
    rel(2'b00);
    check("green", {31'h0, indicator_green}, 32'h1);
  endtask
  task automatic t_func();
    apb(1'b1, OFS_RELAY1, 32'h00050011);
    res(16'd150);
    rel(2'b10);
    res(16'd50);
    rel(2'b10);
    apb(1'b1, OFS_RELAY1, 32'h00050012);
    res(16'd150);
    rel(2'b10);
    res(16'd50);
    rel(2'b00);
    apb(1'b1, OFS_RELAY1, 32'h10);
  endtask
  task automatic t_twopt();
    apb(1'b1, OFS_CTRL, 32'h41);
    res(16'd250);
    rel(2'b11);
    res(16'd150);
    rel(2'b11);
    res(16'd50);
    rel(2'b00);
    res(16'd150);
    rel(2'b10);
  endtask
  task automatic t_range();
    apb(1'b1, OFS_CTRL, 32'h42);
    res(16'd50);
    rel(2'b10);
    res(16'd150);
    rel(2'b00);
    res(16'd250);
    rel(2'b01);
    apb(1'b1, OFS_CTRL, 32'h40);
    res(16'd50);
  endtask
  task automatic t_count();
    apb(1'b1, OFS_RELAY1, 32'h30);
    repeat (2) begin
      res(16'd150);
      rel(2'b00);
      wait_start();
    end
    res(16'd150);
    rel(2'b10);
    res(16'd50);
    res(16'd150);
    rel(2'b00);
    wait_start();
    res(16'd50);
    apb(1'b1, OFS_RELAY1, 32'h20);
    res(16'd150);
    rel(2'b00);
    wait_start();
    res(16'd150);
    rel(2'b10);
    apb(1'b1, OFS_RELAY1, 32'h10);
    res(16'd50);
  endtask
  task automatic t_irq();
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    res(16'd50);
    check("irq set", {31'h0, irq}, 32'h1);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    check("irq status", rd, 32'h1);
    #1;
    check("irq clear", {31'h0, irq}, 32'h0);
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    res(16'd50);
    check("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    check("masked status", rd, 32'h1);
  endtask
  task automatic t_trigger();
    apb(1'b1, OFS_CTRL, 32'h240);
    wait_start();
    res(16'd50);
    apb(1'b1, OFS_VOLUME, 32'h5DC);
    apb(1'b1, OFS_CTRL, 32'h160);
    i_field.send_pulses(1);
    #1;
    check("idle start", {31'h0, analysis_start}, 32'h0);
    i_field.send_pulses(1);
    wait_start();
    res(16'd50);
    apb(1'b1, OFS_CTRL, 32'h40);
  endtask

  task automatic close_out();
    if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    #1;
    t_reset();
    t_limit();
    t_func();
    t_twopt();
    t_range();
    t_count();
    t_irq();
    t_trigger();
    close_out();
  end
endmodule // test_limit_value_relay_control
`default_nettype wire
